/* verilog/lpm_ctrl.sv */
// Low-power mode controller: mode selection, wake-up, registers
`timescale 1ns/1ps
module lpm_ctrl
    import lpm_pkg::*;
#(
    parameter int OSC_START_CYC   = LPM_OSC_START_CYC,
    parameter int REG_RECOVER_CYC = LPM_REG_RECOVER_CYC,
    parameter int CHIP_RESET_CYC  = LPM_CHIP_RESET_CYC
) (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        wait_for_interrupt_instr,
    input  wire logic        wait_for_event_instr,
    input  wire logic        handler_return,
    input  wire logic        sleep_on_handler_exit,
    input  wire logic        deep_sleep_select,
    input  wire logic        irq_pending,
    input  wire logic        event_in,
    input  wire logic        wakeup_pin,
    input  wire logic        external_reset_pin_n,
    input  wire logic        rtc_alarm_evt,
    input  wire logic        rtc_wakeup_evt,
    input  wire logic        tamper_evt,
    input  wire logic        independent_watchdog_rst,
    output logic             core_halt,
    output logic             periph_halt,
    output logic             regulator_low_power,
    output logic             domain_power_off,
    output logic             chip_reset,
    output logic             take_irq_first,
    output logic             restart_from_reset
);
    localparam int CW = 16;
    if (OSC_START_CYC < 1 || REG_RECOVER_CYC < 0 || CHIP_RESET_CYC < 1 ||
        OSC_START_CYC + REG_RECOVER_CYC >= 2**CW || CHIP_RESET_CYC >= 2**CW) begin : g_chk
        $error("lpm_ctrl: timing counts out of range");
    end

    lpm_state_t        state_r, state_nxt;
    logic [CW-1:0]     cnt_r;
    logic              irq_kind_r;
    logic [8:0]        ctrl_r;
    logic              wuf_r, sbf_r, wake_pin_en_r;
    logic [1:0]        wuf_clr_pipe_r;
    logic [1:0]        pin_lvl;
    logic              pin_prev_r;
    logic              extra_r;

    lpm_pin_sync #(.WIDTH(2)) u_sync (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .pin_in    ({~external_reset_pin_n, wakeup_pin}),
        .level_out (pin_lvl)
    );

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) pin_prev_r <= 1'b0;
        else     pin_prev_r <= pin_lvl[0];
    end

    wire pin_rise   = pin_lvl[0] && !pin_prev_r && wake_pin_en_r;
    wire enter_wfi  = wait_for_interrupt_instr || (handler_return && sleep_on_handler_exit);
    wire enter_any  = enter_wfi || wait_for_event_instr;
    wire wake_hit   = irq_kind_r ? irq_pending : event_in;
    wire sb_wake    = pin_rise || rtc_alarm_evt || rtc_wakeup_evt || tamper_evt ||
                      pin_lvl[1] || independent_watchdog_rst;
    wire stop_lp    = ctrl_r[LPM_CTRL_STOP_LP];
    wire pdds       = ctrl_r[LPM_CTRL_PDDS];
    wire go_standby = enter_any && deep_sleep_select && pdds && !wuf_r;

    function automatic logic [CW-1:0] stop_wake_len(input logic lp);
        stop_wake_len = CW'(OSC_START_CYC + (lp ? REG_RECOVER_CYC : 0) - 1);
    endfunction : stop_wake_len

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            LPM_RUN: begin
                // Deep select and wait pulse looked at in the same cycle
                if (enter_any) begin
                    if (!deep_sleep_select)  state_nxt = LPM_SLEEP;
                    else if (!pdds)          state_nxt = LPM_STOP;
                    else if (!wuf_r)         state_nxt = LPM_STANDBY;
                end
            end
            LPM_SLEEP:     if (wake_hit) state_nxt = LPM_RUN;
            LPM_STOP:      if (wake_hit) state_nxt = LPM_STOP_WAKE;
            LPM_STOP_WAKE: if (cnt_r == '0) state_nxt = LPM_RUN;
            LPM_STANDBY:   if (sb_wake) state_nxt = LPM_CHIP_RST;
            LPM_CHIP_RST:  if (cnt_r == '0) state_nxt = LPM_RUN;
            default:       state_nxt = LPM_RUN;
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) state_r <= LPM_RUN;
        else     state_r <= state_nxt;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt_r <= '0;
        end else if (state_r == LPM_STOP && state_nxt == LPM_STOP_WAKE) begin
            cnt_r <= stop_wake_len(stop_lp);
        end else if (state_r == LPM_STANDBY && state_nxt == LPM_CHIP_RST) begin
            cnt_r <= CW'(CHIP_RESET_CYC - 1);
        end else if (cnt_r != '0) begin
            cnt_r <= cnt_r - 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) irq_kind_r <= 1'b0;
        else if (state_r == LPM_RUN && enter_any) irq_kind_r <= enter_wfi;
    end

    // Outputs registered from next state so they change with the mode
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            core_halt           <= 1'b0;
            periph_halt         <= 1'b0;
            regulator_low_power <= 1'b0;
            domain_power_off    <= 1'b0;
            chip_reset          <= 1'b0;
        end else begin
            core_halt           <= state_nxt != LPM_RUN;
            periph_halt         <= state_nxt inside {LPM_STOP, LPM_STOP_WAKE, LPM_STANDBY, LPM_CHIP_RST};
            regulator_low_power <= state_nxt == LPM_STOP && stop_lp;
            domain_power_off    <= state_nxt == LPM_STANDBY;
            chip_reset          <= state_nxt == LPM_CHIP_RST;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            take_irq_first     <= 1'b0;
            restart_from_reset <= 1'b0;
        end else begin
            take_irq_first     <= state_r != LPM_RUN && state_r != LPM_STANDBY && state_r != LPM_CHIP_RST &&
                                  state_nxt == LPM_RUN && irq_kind_r;
            restart_from_reset <= state_r == LPM_CHIP_RST && state_nxt == LPM_RUN;
        end
    end

    // Register bus: status read takes one extra wait cycle
    wire acc      = psel && penable && !pready;
    wire is_ctrl  = paddr == LPM_OFF_CTRL;
    wire is_sts   = paddr == LPM_OFF_STATUS;
    wire need_ext = is_sts && !pwrite && !extra_r;
    wire done     = acc && !need_ext;
    wire wr_ctrl  = done && pwrite && is_ctrl;
    wire wr_sts   = done && pwrite && is_sts;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            extra_r <= 1'b0;
        end else begin
            extra_r <= acc && need_ext;
            pready  <= done;
            pslverr <= done && !is_ctrl && !is_sts;
            if (done && !pwrite) begin
                if (is_ctrl)     prdata <= {23'h000000, ctrl_r[8:4], 2'b00, ctrl_r[1:0]};
                else if (is_sts) prdata <= {23'h000000, wake_pin_en_r, 5'h00, 1'b0, sbf_r, wuf_r};
                else             prdata <= 32'h0000_0000;
            end
        end
    end

    // Clear bits self-clear; whole control resets on standby exit
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) ctrl_r <= LPM_CTRL_RESET;
        else if (state_r == LPM_CHIP_RST) ctrl_r <= LPM_CTRL_RESET;
        else if (wr_ctrl) ctrl_r <= {pwdata[8:4], 2'b00, pwdata[1:0]};
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) wake_pin_en_r <= LPM_STS_RESET[LPM_STS_WAKE_PIN_EN];
        else if (state_r == LPM_CHIP_RST) wake_pin_en_r <= 1'b0;
        else if (wr_sts) wake_pin_en_r <= pwdata[LPM_STS_WAKE_PIN_EN];
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) wuf_clr_pipe_r <= 2'b00;
        else     wuf_clr_pipe_r <= {wuf_clr_pipe_r[0], wr_ctrl && pwdata[LPM_CTRL_WUF_CLR]};
    end

    // Hardware set wins over a clear landing in the same cycle
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) wuf_r <= LPM_STS_RESET[LPM_STS_WUF];
        else if (pin_rise || rtc_alarm_evt) wuf_r <= 1'b1;
        else if (wuf_clr_pipe_r[LPM_WUF_CLR_DELAY-1]) wuf_r <= 1'b0;
    end

    // Survives the standby exit reset; cleared only by reset or a control write with LPM_CTRL_SBF_CLR set
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) sbf_r <= LPM_STS_RESET[LPM_STS_SBF];
        else if (state_nxt == LPM_STANDBY) sbf_r <= 1'b1;
        else if (wr_ctrl && pwdata[LPM_CTRL_SBF_CLR]) sbf_r <= 1'b0;
    end

    // Stop wake cycles counted apart from cnt_r, so the check is independent
    logic [CW-1:0] stop_wait_r;
    logic          stop_lp_at_r;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            stop_wait_r  <= '0;
            stop_lp_at_r <= 1'b0;
        end else if (state_r == LPM_STOP && wake_hit) begin
            stop_wait_r  <= '0;
            stop_lp_at_r <= stop_lp;
        end else if (state_r == LPM_STOP_WAKE) begin
            stop_wait_r <= stop_wait_r + 1'b1;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence s_run_wait_plain;
        state_r == LPM_RUN && enter_any && !deep_sleep_select;
    endsequence
    sequence s_run_wait_deep;
        state_r == LPM_RUN && enter_any && deep_sleep_select;
    endsequence

    a_sleep_entry_now: assert property (s_run_wait_plain |=> state_r == LPM_SLEEP && core_halt && !periph_halt)
        else $error("sleep not entered after wait");
    a_exit_sleep_entry: assert property (state_r == LPM_RUN && handler_return && sleep_on_handler_exit &&
                                         !deep_sleep_select |=> state_r == LPM_SLEEP)
        else $error("sleep-on-exit ignored");
    a_wake_by_kind: assert property (state_r == LPM_SLEEP && !(irq_kind_r ? irq_pending : event_in)
                                     |=> state_r == LPM_SLEEP)
        else $error("woke without matching cause");
    a_sleep_no_delay: assert property (state_r == LPM_SLEEP && wake_hit |=> state_r == LPM_RUN && !core_halt)
        else $error("sleep wake delayed");
    a_irq_resume: assert property (state_r == LPM_SLEEP && wake_hit && irq_kind_r |=> take_irq_first)
        else $error("interrupt not flagged on wake");
    a_stop_entry: assert property (s_run_wait_deep and (!pdds) |=> state_r == LPM_STOP && periph_halt)
        else $error("stop not entered");
    a_stop_regulator: assert property (state_r == LPM_STOP && $past(state_r) == LPM_STOP
                                       |-> regulator_low_power == $past(stop_lp))
        else $error("regulator state wrong in stop");
    a_stop_wake_len: assert property (state_r == LPM_STOP_WAKE && state_nxt == LPM_RUN |-> stop_wait_r ==
                                      CW'(OSC_START_CYC - 1 + (stop_lp_at_r ? REG_RECOVER_CYC : 0)))
        else $error("stop wake latency wrong");
    a_standby_entry: assert property (s_run_wait_deep and (pdds && !wuf_r) |=> state_r == LPM_STANDBY
                                      ##1 domain_power_off && sbf_r)
        else $error("standby not entered");
    a_standby_exit: assert property (state_r == LPM_STANDBY && sb_wake |=> state_r == LPM_CHIP_RST ##1 chip_reset)
        else $error("standby exit missed");
    a_restart_point: assert property ($rose(restart_from_reset) |-> $past(state_r) == LPM_CHIP_RST
                                      && !take_irq_first)
        else $error("restart without chip reset");
    a_flag_set: assert property (rtc_alarm_evt |=> wuf_r)
        else $error("wake flag not set");
    a_deep_sample: assert property (state_r == LPM_RUN && enter_any && deep_sleep_select
                                    |=> state_r != LPM_SLEEP)
        else $error("deep select not honoured");
endmodule : lpm_ctrl

/* verilog/lpm_pkg.sv */
// Shared constants for the low-power mode controller
package lpm_pkg;
    // Register offsets
    localparam logic [7:0] LPM_OFF_CTRL   = 8'h00;
    localparam logic [7:0] LPM_OFF_STATUS = 8'h04;
    // Control register fields
    localparam int LPM_CTRL_STOP_LP   = 0;
    localparam int LPM_CTRL_PDDS      = 1;
    localparam int LPM_CTRL_WUF_CLR   = 2;
    localparam int LPM_CTRL_SBF_CLR   = 3;
    localparam int LPM_CTRL_PVD_EN    = 4;
    localparam int LPM_CTRL_PLSEL_LO  = 5;
    localparam int LPM_CTRL_PLSEL_HI  = 7;
    localparam int LPM_CTRL_BKP_WEN   = 8;
    // Status register fields
    localparam int LPM_STS_WUF        = 0;
    localparam int LPM_STS_SBF        = 1;
    localparam int LPM_STS_PVD_OUT    = 2;
    localparam int LPM_STS_WAKE_PIN_EN = 8;
    localparam logic [8:0] LPM_CTRL_RESET = 9'h000;
    localparam logic [8:0] LPM_STS_RESET  = 9'h000;
    // Wake-up flag clear lands this many cycles after the write
    localparam int LPM_WUF_CLR_DELAY  = 2;
    // Timing, in ns, and derived cycle counts at the system clock
    localparam int LPM_CLK_PERIOD_NS  = 100;
    localparam int LPM_OSC_START_NS   = 2000;
    localparam int LPM_REG_RECOVER_NS = 5000;
    localparam int LPM_CHIP_RESET_NS  = 100000;
    localparam int LPM_OSC_START_CYC  = (LPM_OSC_START_NS + LPM_CLK_PERIOD_NS - 1) / LPM_CLK_PERIOD_NS;
    localparam int LPM_REG_RECOVER_CYC = (LPM_REG_RECOVER_NS + LPM_CLK_PERIOD_NS - 1) / LPM_CLK_PERIOD_NS;
    localparam int LPM_CHIP_RESET_CYC = (LPM_CHIP_RESET_NS + LPM_CLK_PERIOD_NS - 1) / LPM_CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        LPM_RUN       = 3'b000,
        LPM_SLEEP     = 3'b001,
        LPM_STOP      = 3'b010,
        LPM_STOP_WAKE = 3'b011,
        LPM_STANDBY   = 3'b100,
        LPM_CHIP_RST  = 3'b101
    } lpm_state_t;
endpackage : lpm_pkg

/* verilog/lpm_pin_sync.sv */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module lpm_pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             ref_clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] level_out
);
    logic [WIDTH-1:0] s1_r;
    logic [WIDTH-1:0] s2_r;
    logic [WIDTH-1:0] s3_r;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end else begin
            s1_r <= pin_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // A change counts only once stages two and three agree
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            level_out <= '0;
        end else begin
            for (int i = 0; i < WIDTH; i++) begin
                if (s2_r[i] == s3_r[i]) begin
                    level_out[i] <= s3_r[i];
                end
            end
        end
    end
endmodule : lpm_pin_sync

/* tb/lpm_core_model.sv */
// Core-side model: wait instructions, handler return, wake requests
`timescale 1ns/1ps
module lpm_core_model (
    input  wire logic ref_clk,
    input  wire logic core_halt,
    output logic      wait_irq,
    output logic      wait_evt,
    output logic      hret,
    output logic      soe,
    output logic      deep,
    output logic      irq,
    output logic      evt
);
    // Run-mode clock trimming left to software, not modelled
    initial begin
        {wait_irq, wait_evt, hret, soe, deep, irq, evt} = 7'h00;
    end
    // Deep select settles a cycle ahead of the wait pulse
    task automatic exec_wait(input bit by_evt, input bit dp);
        deep <= dp;
        @(posedge ref_clk);
        wait_evt <= by_evt;
        wait_irq <= !by_evt;
        @(posedge ref_clk);
        {wait_irq, wait_evt} <= 2'b00;
    endtask : exec_wait
    task automatic handler_ret();
        soe <= 1'b1;
        @(posedge ref_clk);
        hret <= 1'b1;
        @(posedge ref_clk);
        hret <= 1'b0;
    endtask : handler_ret
    // Interrupt held until the core runs, as a real request would be
    task automatic wake(input bit by_irq, input int dly);
        int n;
        repeat (dly) @(posedge ref_clk);
        irq <= by_irq;
        evt <= !by_irq;
        @(posedge ref_clk);
        evt <= 1'b0;
        for (n = 0; n < 200 && core_halt !== 1'b0; n++) @(posedge ref_clk);
        irq <= 1'b0;
        soe <= 1'b0;
        @(posedge ref_clk);
    endtask : wake
endmodule : lpm_core_model

/* tb/tb_low_power_mode_controller.sv */
// Testbench for the low-power mode controller
`timescale 1ns/1ps
module tb_low_power_mode_controller;
    import lpm_pkg::*;
    // Short counts keep the run brief
    localparam int OSC  = 3;
    localparam int REG  = 2;
    localparam int CRST = 4;
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic        pready, pslverr, e;
    logic        wait_irq, wait_evt, hret, soe, deep, irq, evt;
    logic        wakeup_pin = 1'b0, external_reset_pin_n = 1'b1;
    logic        rtc_alarm_evt = 1'b0, rtc_wakeup_evt = 1'b0, tamper_evt = 1'b0;
    logic        independent_watchdog_rst = 1'b0;
    logic        core_halt, periph_halt, regulator_low_power, domain_power_off;
    logic        chip_reset, take_irq_first, restart_from_reset;
    int          n_errors = 0, total_checks = 0, seed = 98902;
    int          n_irqf = 0, n_rst = 0, n_crst = 0, lat = 0, i, j, k, ctrl_m;

    always #50 ref_clk = ~ref_clk;

    lpm_ctrl #(.OSC_START_CYC(OSC), .REG_RECOVER_CYC(REG), .CHIP_RESET_CYC(CRST)) i_lpm_ctrl (
        .ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .wait_for_interrupt_instr(wait_irq), .wait_for_event_instr(wait_evt), .handler_return(hret),
        .sleep_on_handler_exit(soe), .deep_sleep_select(deep), .irq_pending(irq), .event_in(evt),
        .wakeup_pin, .external_reset_pin_n, .rtc_alarm_evt, .rtc_wakeup_evt, .tamper_evt,
        .independent_watchdog_rst, .core_halt, .periph_halt, .regulator_low_power,
        .domain_power_off, .chip_reset, .take_irq_first, .restart_from_reset
    );
    lpm_core_model i_lpm_core_model (.ref_clk, .core_halt, .wait_irq, .wait_evt, .hret, .soe, .deep, .irq, .evt);

    // Tallies of one-cycle pulses, of chip reset cycles and of wake latency
    always @(posedge ref_clk) begin
        n_irqf <= n_irqf + (take_irq_first === 1'b1);
        n_rst  <= n_rst + (restart_from_reset === 1'b1);
        n_crst <= n_crst + (chip_reset === 1'b1);
        lat    <= lat + (irq === 1'b1 && core_halt === 1'b1);
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask : chk

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        for (n = 0; n < 8; n++) begin
            @(posedge ref_clk);
            if (pready === 1'b1) break;
        end
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask : bus

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string m);
        bus(1'b0, a, 32'h0);
        chk(q, exp, m);
    endtask : rd

    task automatic summarize();
        $display("checks %0d, mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : summarize

    initial begin
        #(5000 * 100);
        n_errors++;
        $display("wrong value at %0t: watchdog expired", $time);
        summarize();
    end

    initial begin
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        rd(LPM_OFF_CTRL, 32'h0, "ctrl reset");
        rd(LPM_OFF_STATUS, 32'h0, "status reset");
        for (i = 0; i < 4; i++) begin
            ctrl_m = $random(seed);
            bus(1'b1, LPM_OFF_CTRL, ctrl_m);
            rd(LPM_OFF_CTRL, ctrl_m & 32'h1F3, "ctrl rw");
        end
        bus(1'b1, LPM_OFF_CTRL, 32'h0);
        rd(8'h08, 32'h0, "unmapped data");
        chk(e, 1'b1, "unmapped error");
        $display("test registers done");
        for (k = 0; k < 2; k++) begin
            i = n_irqf;
            j = lat;
            i_lpm_core_model.exec_wait(k[0], 1'b0);
            repeat (3) @(posedge ref_clk);
            chk({core_halt, periph_halt}, 2'b10, "sleep halt");
            i_lpm_core_model.wake(!k[0], 5);
            repeat (3) @(posedge ref_clk);
            chk(core_halt, 1'b0, "sleep wake");
            chk(n_irqf - i, 1 - k, "irq first");
            chk((lat - j) <= 2, 1'b1, "sleep wake delay");
        end
        i_lpm_core_model.handler_ret();
        repeat (3) @(posedge ref_clk);
        chk(core_halt, 1'b1, "sleep on exit");
        i_lpm_core_model.wake(1'b1, 2);
        $display("test sleep done");
        for (k = 0; k < 2; k++) begin
            bus(1'b1, LPM_OFF_CTRL, k);
            j = lat;
            i_lpm_core_model.exec_wait(1'b0, 1'b1);
            repeat (3) @(posedge ref_clk);
            chk({core_halt, periph_halt, regulator_low_power}, {2'b11, k[0]}, "stop entry");
            i_lpm_core_model.wake(1'b1, 4);
            repeat (2) @(posedge ref_clk);
            j = lat - j - OSC - k * REG;
            chk(j >= 0 && j <= 4, 1'b1, "stop wake delay");
            chk(regulator_low_power, 1'b0, "regulator back");
        end
        $display("test stop done");
        bus(1'b1, LPM_OFF_STATUS, 32'h100);
        wakeup_pin <= 1'b1;
        repeat (8) @(posedge ref_clk);
        wakeup_pin <= 1'b0;
        rd(LPM_OFF_STATUS, 32'h101, "wake flag set");
        bus(1'b1, LPM_OFF_CTRL, 32'h2);
        i_lpm_core_model.exec_wait(1'b0, 1'b1);
        repeat (3) @(posedge ref_clk);
        chk({core_halt, domain_power_off}, 2'b00, "standby refused");
        bus(1'b1, LPM_OFF_CTRL, 32'h6);
        repeat (3) @(posedge ref_clk);
        rd(LPM_OFF_STATUS, 32'h100, "wake flag clear");
        $display("test wake flag done");
        for (i = 0; i < 6; i++) begin
            bus(1'b1, LPM_OFF_CTRL, 32'h6);
            bus(1'b1, LPM_OFF_STATUS, 32'h100);
            repeat (3) @(posedge ref_clk);
            j = n_crst;
            k = n_rst;
            i_lpm_core_model.exec_wait(i[0], 1'b1);
            repeat (3) @(posedge ref_clk);
            chk({core_halt, periph_halt, domain_power_off}, 3'b111, "standby entry");
            case (i)
                0: wakeup_pin <= 1'b1;
                1: rtc_alarm_evt <= 1'b1;
                2: rtc_wakeup_evt <= 1'b1;
                3: tamper_evt <= 1'b1;
                4: independent_watchdog_rst <= 1'b1;
                default: external_reset_pin_n <= 1'b0;
            endcase
            @(posedge ref_clk);
            {rtc_alarm_evt, rtc_wakeup_evt, tamper_evt, independent_watchdog_rst} <= 4'h0;
            repeat (5) @(posedge ref_clk);
            wakeup_pin <= 1'b0;
            external_reset_pin_n <= 1'b1;
            repeat (CRST + 10) @(posedge ref_clk);
            // Pin causes get only a lower-bound check; no cause stretches the reset past CRST cycles
            chk(n_crst - j >= CRST && (i % 5 == 0 || n_crst - j == CRST), 1'b1, "chip reset len");
            chk(n_rst - k, 1, "restart pulse");
            chk({core_halt, domain_power_off}, 2'b00, "standby exit");
            rd(LPM_OFF_CTRL, 32'h0, "ctrl cleared");
            bus(1'b0, LPM_OFF_STATUS, 32'h0);
            chk(q & 32'h102, 32'h002, "standby flag");
        end
        $display("test standby done");
        summarize();
    end
endmodule : tb_low_power_mode_controller
